// ==== shared/abs_pos_pkg.sv ====
// shared constants of the absolute position tracker
package abs_pos_pkg;
  // register byte offsets
  localparam logic [5:0] OFS_FB_AFTER  = 6'h00;
  localparam logic [5:0] OFS_CTRL      = 6'h04;
  localparam logic [5:0] OFS_UPDATE    = 6'h08;
  localparam logic [5:0] OFS_TURN      = 6'h0c;
  localparam logic [5:0] OFS_INTURN    = 6'h10;
  localparam logic [5:0] OFS_STATUS    = 6'h14;
  localparam logic [5:0] OFS_IRQ_CLR   = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN    = 6'h1c;
  localparam logic [5:0] OFS_ENC_STAT  = 6'h20;
  localparam logic [5:0] OFS_FB_BEFORE = 6'h24;
  localparam logic [5:0] OFS_GEAR      = 6'h28;
  localparam logic [5:0] OFS_POS_ERR   = 6'h2c;
  // control register fields
  localparam int CTRL_RES_LSB   = 0;
  localparam int CTRL_ABS_EN    = 2;
  localparam int CTRL_COORD_SET = 3;
  localparam int CTRL_HOME      = 4;
  localparam int CTRL_PARAM_MODE = 5;
  localparam int CTRL_MODE_LSB  = 6;
  localparam int CTRL_STROKELESS = 9;
  localparam int CTRL_ALM_CODE  = 10;
  localparam int CTRL_GEAR_CHG  = 11;
  // alarm / event bit positions
  localparam int ALM_OVERFLOW   = 0;
  localparam int ALM_COORD_LOST = 1;
  localparam int ALM_BAT_REPL   = 2;
  localparam int ALM_MISMATCH   = 3;
  localparam int EVT_UPD_DONE   = 4;
  localparam int NUM_EVT        = 5;
  // absolute update command values
  localparam logic [1:0] UPD_IDLE  = 2'h0;
  localparam logic [1:0] UPD_KEEP  = 2'h1;
  localparam logic [1:0] UPD_CLEAR = 2'h2;
  // turn range and per-turn resolutions (shift = log2 of pulses per turn)
  localparam logic signed [15:0] TURN_MAX = 16'sh7fff;
  localparam logic signed [15:0] TURN_MIN = 16'sh8000;
  localparam logic [4:0] SHIFT_RES0 = 5'h14;
  localparam logic [4:0] SHIFT_RES1 = 5'h16;
  localparam logic [4:0] SHIFT_RES2 = 5'h17;
  localparam logic [15:0] GEAR_RESET = 16'h8000;
  localparam int GEAR_FRAC = 15;
  // control modes
  localparam logic [2:0] MODE_POSITION = 3'h0;
endpackage : abs_pos_pkg

// ==== verilog/pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  input  wire logic ref_clk,  // system clock
  input  wire logic rst,      // synchronous reset
  input  wire logic pinIn,    // asynchronous pin
  output logic      levelOut  // filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // s1 feeds only s2 so metastability never reaches logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      levelOut <= 1'b0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        levelOut <= s3_r;
      end
    end
  end
endmodule : pin_sync

// ==== verilog/turn_tracker.sv ====
// multi-turn and in-turn pulse counter
`timescale 1ns/1ps
module turn_tracker (
  input  wire logic               ref_clk,   // system clock
  input  wire logic               clr,       // zero the coordinate (battery domain)
  input  wire logic               step,      // one feedback pulse
  input  wire logic               up,        // direction of the pulse
  input  wire logic [4:0]         shift,     // log2 of pulses per turn
  output logic signed [15:0]      turn,      // turn count
  output logic [22:0]             inTurn,    // pulse within turn
  output logic                    wrapPulse  // turn count left its range
);
  logic [22:0] topPulse;
  assign topPulse = 23'((24'h1 << shift) - 24'h1);

  // counters are deliberately untouched by the main reset: battery backed
  always_ff @(posedge ref_clk) begin
    wrapPulse <= 1'b0;
    if (clr) begin
      turn   <= '0;
      inTurn <= '0;
    end else if (step) begin
      if (up) begin
        if (inTurn >= topPulse) begin
          inTurn <= '0;
          turn   <= turn + 16'sh1;
          wrapPulse <= (turn == abs_pos_pkg::TURN_MAX);
        end else begin
          inTurn <= inTurn + 23'h1;
        end
      end else begin
        if (inTurn == 23'h0) begin
          inTurn <= topPulse;
          turn   <= turn - 16'sh1;
          wrapPulse <= (turn == abs_pos_pkg::TURN_MIN);
        end else begin
          inTurn <= inTurn - 23'h1;
        end
      end
    end
  end
endmodule : turn_tracker

// ==== verilog/abs_position_tracker.sv ====
// absolute multi-turn position tracker with avalon register slave
`timescale 1ns/1ps
// How it works
// - signed turn count -32768..32767; leaving the range raises turn overflow alarm.
// - resolution select 0/1/2 gives 2^20, 2^22, 2^23 pulses per turn.
// - total position is turn times pulses per turn plus in-turn pulses.
// - absolute operation with incremental motor attached raises motor mismatch alarm.
// - before coordinates are first set, coordinate lost alarm stays up.
// - battery depletion destroying coordinates also raises coordinate lost alarm.
// - first power-up after battery change raises battery alarm; next power cycle clears.
// - coordinate set clears coordinate lost; homing in parameter mode marks coordinates lost.
// - after power returns turn and in-turn position are readable by the host.
// - feedback after gear at 0x00, before gear at 0x24, one 32-bit word each.
// - host write of update command refreshes encoder status and position.
// - update value 1 keeps position errors on read; value 2 clears them.
// - device returns update command to 0 when refresh is done.
// - position lost or turn overflow marks absolute position invalid.
// - absolute operation unsupported in non-position modes, strokeless, gear change, alarm code.
// - position store survives main power loss; only battery loss or coordinate set resets it.
// - at standstill small corrections happen; coordinate set clears position error.
// - absolute enable takes effect only after the next power cycle.
module abs_position_tracker (
  input  wire logic        ref_clk,          // 100 MHz clock
  input  wire logic        rst,              // main power reset, sync active high
  input  wire logic        batRst,           // battery domain reset, sync active high
  input  wire logic        encStepPin,       // encoder feedback pulse pin
  input  wire logic        encDirPin,        // encoder direction pin, high counts up
  input  wire logic        incrementalPin,   // high when an incremental motor is fitted
  input  wire logic        batDepletedPin,   // high when backup battery has collapsed
  input  wire logic        batReplacedPin,   // high when battery was just replaced
  input  wire logic [5:0]  avs_address,      // avalon byte address
  input  wire logic        avs_read,         // avalon read
  input  wire logic        avs_write,        // avalon write
  input  wire logic [31:0] avs_writedata,    // avalon write data
  input  wire logic [3:0]  avs_byteenable,   // avalon byte enables
  output logic [31:0]      avs_readdata,     // avalon read data
  output logic             avs_waitrequest,  // avalon wait request
  output logic             irq,              // level interrupt
  output logic             turnOverflowAlarm, // turn overflow alarm
  output logic             coordLostAlarm,   // coordinate lost alarm
  output logic             batReplacedAlarm, // battery replaced alarm
  output logic             mismatchAlarm,    // motor type mismatch alarm
  output logic             posValid          // absolute position is trustworthy
);
  typedef enum logic [1:0] {
    UPD_WAIT = 2'b00,
    UPD_SNAP = 2'b01,
    UPD_DONE = 2'b10
  } upd_state_e;
  localparam int NUM_EVT_W = abs_pos_pkg::NUM_EVT;

  logic                stepLvl;
  logic                dirLvl;
  logic                incLvl;
  logic                batDepLvl;
  logic                batRepLvl;
  logic                stepLvlD_r;
  logic                stepEvt;
  logic signed [15:0]  turn;
  logic [22:0]         inTurn;
  logic                wrapPulse;
  logic [31:0]         ctrl_r;
  logic                absEnReq_r;
  logic                absActive_r;
  logic                coordValid_r;
  logic                overflow_r;
  logic                batRepl_r;
  logic                rstD_r;
  logic [1:0]          updCmd_r;
  logic [1:0]          updMode_r;
  upd_state_e          updState_r;
  logic signed [15:0]  snapTurn_r;
  logic [22:0]         snapInTurn_r;
  logic [31:0]         snapBefore_r;
  logic [31:0]         snapAfter_r;
  logic [3:0]          snapStat_r;
  logic [15:0]         gear_r;
  logic [31:0]         posErr_r;
  logic [NUM_EVT_W-1:0] evtStat_r;
  logic [NUM_EVT_W-1:0] evtEn_r;
  logic [NUM_EVT_W-1:0] evtNow;
  logic [NUM_EVT_W-1:0] almD_r;
  logic                unsupported;
  logic [4:0]          shift;
  logic signed [47:0]  total;
  logic [47:0]         afterGear;
  logic                wrAcc;
  logic                rdAcc;
  logic                coordSetCmd;
  logic                homeCmd;
  logic                coordClr;
  logic                posRead;
  logic [31:0]         rdData;

  function automatic logic [4:0] resShift(input logic [1:0] sel);
    unique case (sel)
      2'h1:    resShift = abs_pos_pkg::SHIFT_RES1;
      2'h2:    resShift = abs_pos_pkg::SHIFT_RES2;
      default: resShift = abs_pos_pkg::SHIFT_RES0;
    endcase
  endfunction : resShift

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    mergeBytes = old;
  endfunction : mergeBytes

  // pin inputs
  pin_sync u_syncStep (.ref_clk(ref_clk), .rst(rst), .pinIn(encStepPin),     .levelOut(stepLvl));
  pin_sync u_syncDir  (.ref_clk(ref_clk), .rst(rst), .pinIn(encDirPin),      .levelOut(dirLvl));
  pin_sync u_syncInc  (.ref_clk(ref_clk), .rst(rst), .pinIn(incrementalPin), .levelOut(incLvl));
  pin_sync u_syncDep  (.ref_clk(ref_clk), .rst(rst), .pinIn(batDepletedPin), .levelOut(batDepLvl));
  // battery reset only, so the pin level is already settled when the power reset lets go
  pin_sync u_syncRep  (.ref_clk(ref_clk), .rst(batRst), .pinIn(batReplacedPin), .levelOut(batRepLvl));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stepLvlD_r <= 1'b0;
    end else begin
      stepLvlD_r <= stepLvl;
    end
  end
  assign stepEvt = stepLvl & ~stepLvlD_r;

  // bus access qualifiers: an access is taken on the edge where waitrequest is low
  assign wrAcc = avs_write & ~avs_waitrequest;
  assign rdAcc = avs_read & ~avs_waitrequest;
  assign coordSetCmd = wrAcc && avs_address == abs_pos_pkg::OFS_CTRL && avs_byteenable[0]
                       && avs_writedata[abs_pos_pkg::CTRL_COORD_SET];
  assign homeCmd = wrAcc && avs_address == abs_pos_pkg::OFS_CTRL && avs_byteenable[0]
                   && avs_writedata[abs_pos_pkg::CTRL_HOME] && ctrl_r[abs_pos_pkg::CTRL_PARAM_MODE];
  assign posRead = rdAcc && (avs_address == abs_pos_pkg::OFS_FB_AFTER
                             || avs_address == abs_pos_pkg::OFS_FB_BEFORE);
  // battery loss or coordinate set both restart the coordinate at zero
  assign coordClr = batRst | batDepLvl | coordSetCmd;

  assign shift = resShift(ctrl_r[abs_pos_pkg::CTRL_RES_LSB +: 2]);

  turn_tracker u_tracker (
    .ref_clk  (ref_clk),
    .clr      (coordClr),
    .step     (stepEvt),
    .up       (dirLvl),
    .shift    (shift),
    .turn     (turn),
    .inTurn   (inTurn),
    .wrapPulse(wrapPulse)
  );

  // pulses per turn is a power of two, so the product is a shift
  assign total = (48'(signed'(turn)) <<< shift) + 48'(inTurn);
  assign afterGear = 48'((64'(total) * 64'(gear_r)) >> abs_pos_pkg::GEAR_FRAC);

  assign unsupported = ctrl_r[abs_pos_pkg::CTRL_MODE_LSB +: 3] != abs_pos_pkg::MODE_POSITION
                       || ctrl_r[abs_pos_pkg::CTRL_STROKELESS]
                       || ctrl_r[abs_pos_pkg::CTRL_GEAR_CHG]
                       || ctrl_r[abs_pos_pkg::CTRL_ALM_CODE];

  // nonvolatile parameters live in the battery domain
  always_ff @(posedge ref_clk) begin
    if (batRst) begin
      absEnReq_r <= 1'b0;
    end else if (wrAcc && avs_address == abs_pos_pkg::OFS_CTRL && avs_byteenable[0]) begin
      absEnReq_r <= avs_writedata[abs_pos_pkg::CTRL_ABS_EN];
    end
  end

  // absolute mode follows the request only across a power cycle
  always_ff @(posedge ref_clk) begin
    rstD_r <= rst;
    if (rst) begin
      absActive_r <= 1'b0;
      batRepl_r   <= 1'b0;
    end else if (rstD_r) begin
      absActive_r <= absEnReq_r;
      batRepl_r   <= batRepLvl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= '0;
      gear_r <= abs_pos_pkg::GEAR_RESET;
    end else if (wrAcc && avs_address == abs_pos_pkg::OFS_CTRL) begin
      ctrl_r <= mergeBytes(ctrl_r, avs_writedata, avs_byteenable)
                & ~(32'h1 << abs_pos_pkg::CTRL_COORD_SET) & ~(32'h1 << abs_pos_pkg::CTRL_HOME);
    end else if (wrAcc && avs_address == abs_pos_pkg::OFS_GEAR) begin
      gear_r <= 16'(mergeBytes({16'h0, gear_r}, avs_writedata, avs_byteenable));
    end
  end

  // coordinate validity is battery backed, so it survives main power loss
  always_ff @(posedge ref_clk) begin
    if (batRst || batDepLvl) begin
      coordValid_r <= 1'b0;
    end else if (homeCmd) begin
      coordValid_r <= 1'b0;
    end else if (coordSetCmd) begin
      coordValid_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (batRst) begin
      overflow_r <= 1'b0;
    end else if (coordSetCmd) begin
      overflow_r <= 1'b0;
    end else if (wrapPulse) begin
      overflow_r <= 1'b1;
    end
  end

  // position error: feedback pulses not yet acknowledged by the host
  always_ff @(posedge ref_clk) begin
    if (rst || coordSetCmd) begin
      posErr_r <= '0;
    end else if (posRead && updMode_r == abs_pos_pkg::UPD_CLEAR) begin
      posErr_r <= '0;
    end else if (stepEvt) begin
      posErr_r <= posErr_r + 32'h1;
    end
  end

  // alarm outputs, all from flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      turnOverflowAlarm <= 1'b0;
      coordLostAlarm    <= 1'b0;
      batReplacedAlarm  <= 1'b0;
      mismatchAlarm     <= 1'b0;
      posValid          <= 1'b0;
    end else begin
      turnOverflowAlarm <= absActive_r & overflow_r;
      coordLostAlarm    <= absActive_r & ~coordValid_r;
      batReplacedAlarm  <= absActive_r & batRepl_r;
      mismatchAlarm     <= absActive_r & incLvl;
      posValid          <= absActive_r & coordValid_r & ~overflow_r & ~unsupported
                           & ~incLvl;
    end
  end

  // update command sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      updState_r <= UPD_WAIT;
      updCmd_r   <= abs_pos_pkg::UPD_IDLE;
      updMode_r  <= abs_pos_pkg::UPD_KEEP;
    end else begin
      unique case (updState_r)
        UPD_WAIT: begin
          if (wrAcc && avs_address == abs_pos_pkg::OFS_UPDATE && avs_byteenable[0]
              && (avs_writedata[1:0] == abs_pos_pkg::UPD_KEEP
                  || avs_writedata[1:0] == abs_pos_pkg::UPD_CLEAR)) begin
            updCmd_r   <= avs_writedata[1:0];
            updMode_r  <= avs_writedata[1:0];
            updState_r <= UPD_SNAP;
          end
        end
        UPD_SNAP: updState_r <= UPD_DONE;
        UPD_DONE: begin
          updCmd_r   <= abs_pos_pkg::UPD_IDLE;
          updState_r <= UPD_WAIT;
        end
        default: updState_r <= UPD_WAIT;
      endcase
    end
  end

  // snapshot is what the host reads; it only moves on a refresh or a main reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snapTurn_r   <= '0;
      snapInTurn_r <= '0;
      snapBefore_r <= '0;
      snapAfter_r  <= '0;
      snapStat_r   <= '0;
    end else if (updState_r == UPD_SNAP) begin
      snapTurn_r   <= turn;
      snapInTurn_r <= inTurn;
      snapBefore_r <= total[31:0];
      snapAfter_r  <= afterGear[31:0];
      snapStat_r   <= {unsupported, ~coordValid_r, overflow_r, posValid};
    end
  end

  // interrupt events are rising edges of alarms plus refresh completion
  assign evtNow = {updState_r == UPD_DONE, mismatchAlarm, batReplacedAlarm, coordLostAlarm,
                   turnOverflowAlarm};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      almD_r    <= '0;
      evtStat_r <= '0;
      evtEn_r   <= '0;
      irq       <= 1'b0;
    end else begin
      almD_r <= evtNow;
      // a new event in the clearing cycle is kept: set wins
      evtStat_r <= (evtStat_r & ~((wrAcc && avs_address == abs_pos_pkg::OFS_IRQ_CLR)
                                  ? avs_writedata[NUM_EVT_W-1:0] : '0))
                   | (evtNow & ~almD_r);
      if (wrAcc && avs_address == abs_pos_pkg::OFS_IRQ_EN) begin
        evtEn_r <= avs_writedata[NUM_EVT_W-1:0];
      end
      irq <= |(evtStat_r & evtEn_r);
    end
  end

  always_comb begin
    rdData = '0;
    unique case (avs_address)
      abs_pos_pkg::OFS_FB_AFTER:  rdData = snapAfter_r;
      abs_pos_pkg::OFS_FB_BEFORE: rdData = snapBefore_r;
      abs_pos_pkg::OFS_CTRL:      rdData = ctrl_r | (32'(absEnReq_r) << abs_pos_pkg::CTRL_ABS_EN);
      abs_pos_pkg::OFS_UPDATE:    rdData = 32'(updCmd_r);
      abs_pos_pkg::OFS_TURN:      rdData = 32'(signed'(snapTurn_r));
      abs_pos_pkg::OFS_INTURN:    rdData = 32'(snapInTurn_r);
      abs_pos_pkg::OFS_STATUS:    rdData = 32'(evtStat_r);
      abs_pos_pkg::OFS_IRQ_EN:    rdData = 32'(evtEn_r);
      abs_pos_pkg::OFS_ENC_STAT:  rdData = {27'h0, absActive_r, snapStat_r};
      abs_pos_pkg::OFS_GEAR:      rdData = 32'(gear_r);
      abs_pos_pkg::OFS_POS_ERR:   rdData = posErr_r;
      default:                    rdData = '0;
    endcase
  end

  // one wait cycle per access; unmapped addresses answer zero and ignore writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rdData;
      end
    end
  end
endmodule : abs_position_tracker

// ==== tb/encoder_model.sv ====
// behavioural encoder driving the step and direction pins
`timescale 1ns/1ps
module encoder_model (
  input  wire logic       ref_clk,  // system clock
  input  wire logic       go,       // start a pulse train
  input  wire logic       up,       // direction of the train
  input  wire logic [7:0] count,    // pulses in the train
  output logic            stepPin,  // step pin
  output logic            dirPin,   // direction pin
  output logic            busy      // train in progress
);
  initial begin
    stepPin = 1'b0;
    dirPin  = 1'b1;
    busy    = 1'b0;
  end
  // five cycles high and low keeps above the two that the pin filter needs
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      busy   <= 1'b1;
      dirPin <= up;
      repeat (count) begin
        repeat (5) @(posedge ref_clk);
        stepPin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        stepPin <= 1'b0;
      end
      repeat (5) @(posedge ref_clk);
      busy <= 1'b0;
    end
  end
endmodule : encoder_model

// ==== tb/abs_position_tracker_sva.sv ====
// port-level assertions of the position tracker
`timescale 1ns/1ps
module abs_position_tracker_sva (
  input wire logic        ref_clk,           // clock
  input wire logic        rst,               // main reset
  input wire logic        batRst,            // battery reset
  input wire logic        batDepletedPin,    // battery collapsed
  input wire logic [5:0]  avs_address,       // address
  input wire logic        avs_read,          // read
  input wire logic        avs_write,         // write
  input wire logic [31:0] avs_readdata,      // read data
  input wire logic        avs_waitrequest,   // wait request
  input wire logic        irq,               // interrupt
  input wire logic        turnOverflowAlarm, // overflow alarm
  input wire logic        coordLostAlarm,    // coordinate lost alarm
  input wire logic        batReplacedAlarm,  // battery alarm
  input wire logic        mismatchAlarm,     // mismatch alarm
  input wire logic        posValid           // position valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic req = avs_read || avs_write;
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  ans_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer stood longer than one cycle");
  ans_cause_a: assert property (!avs_waitrequest |-> $past(req))
    else $error("answer without a request");
  idle_hold_a: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer while idle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[5:4] == 2'h3 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($past(rst) |-> !irq && !posValid && !coordLostAlarm && !batReplacedAlarm
    && !mismatchAlarm && !turnOverflowAlarm)
    else $error("outputs active right after reset");
  lost_invalid_a: assert property (coordLostAlarm && $past(coordLostAlarm) |-> !posValid)
    else $error("position valid while coordinates lost");
  ovf_invalid_a: assert property (turnOverflowAlarm && $past(turnOverflowAlarm) |-> !posValid)
    else $error("position valid after turn overflow");
  bat_clear_a: assert property (batRst |-> ##[1:3] !posValid)
    else $error("battery reset kept position valid");
  depleted_a: assert property (batDepletedPin [*8] |-> ##[0:4] !posValid)
    else $error("depleted battery kept position valid");
  cover property (avs_read && !avs_waitrequest);
  cover property (irq);
  cover property ($fell(coordLostAlarm));
  cover property (batReplacedAlarm);
endmodule : abs_position_tracker_sva

bind abs_position_tracker abs_position_tracker_sva i_sva (.ref_clk(ref_clk), .rst(rst), .batRst(batRst),
  .batDepletedPin(batDepletedPin), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .turnOverflowAlarm(turnOverflowAlarm), .coordLostAlarm(coordLostAlarm),
  .batReplacedAlarm(batReplacedAlarm), .mismatchAlarm(mismatchAlarm), .posValid(posValid));

// ==== tb/absolute_position_tracker_tb_top.sv ====
// self-checking bench of the absolute position tracker
`timescale 1ns/1ps
module absolute_position_tracker_tb_top;
  typedef struct {logic [1:0] res; logic [31:0] inTurn;} row_s;
  logic        ref_clk, rst, batRst, incr, depl, repl, rd, wr, go, up;
  logic [5:0]  adr;
  logic [7:0]  cnt;
  logic [31:0] wdat, got;
  wire logic [31:0] rdat;
  wire logic   stepPin, dirPin, busy, wreq, irq, ovfA, lostA, replA, misA, pv;
  int          fails, nChecks, cyc;
  row_s        rows[3] = '{'{2'h0, 32'h000fffff}, '{2'h1, 32'h003fffff}, '{2'h2, 32'h007fffff}};

  encoder_model i_encoder_model (.ref_clk(ref_clk), .go(go), .up(up), .count(cnt), .stepPin(stepPin),
    .dirPin(dirPin), .busy(busy));
  abs_position_tracker i_abs_position_tracker (.ref_clk(ref_clk), .rst(rst), .batRst(batRst),
    .encStepPin(stepPin), .encDirPin(dirPin), .incrementalPin(incr), .batDepletedPin(depl),
    .batReplacedPin(repl), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq), .irq(irq),
    .turnOverflowAlarm(ovfA), .coordLostAlarm(lostA), .batReplacedAlarm(replA), .mismatchAlarm(misA),
    .posValid(pv));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    nChecks++;
    if (v !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic e, input logic v);
    chk(nm, {31'h0, e}, {31'h0, v});
  endtask : chkb
  // the request stays up until waitrequest is sampled low, read data taken there
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk);
    end while (wreq !== 1'b0);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, got);
  endtask : rdchk
  task automatic upd(input logic [1:0] m);
    int n;
    n = 0;
    xfer(1'b1, abs_pos_pkg::OFS_UPDATE, {30'h0, m});
    do begin
      xfer(1'b0, abs_pos_pkg::OFS_UPDATE, 32'h0);
      n++;
    end while (got !== 32'h0 && n < 20);
    chk("update", 32'h0, got);
  endtask : upd
  task automatic move(input logic u, input logic [7:0] c);
    int n;
    n = 0;
    up <= u;
    cnt <= c;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (8) @(posedge ref_clk);
  endtask : move
  task automatic pwr(input logic b);
    rst <= 1'b1;
    repl <= b;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    repl <= 1'b0;
  endtask : pwr

  initial begin
    {rst, batRst, incr, depl, repl, rd, wr, go, up} = 9'h180;
    {adr, cnt, wdat} = '0;
    repeat (6) @(posedge ref_clk);
    {rst, batRst} <= 2'h0;
    @(posedge ref_clk);
    rdchk("gear", abs_pos_pkg::OFS_GEAR, 32'h00008000);
    xfer(1'b1, 6'h30, 32'hffffffff);
    rdchk("unmapped", 6'h30, 32'h0);
    xfer(1'b1, abs_pos_pkg::OFS_CTRL, 32'h5);
    pwr(1'b1);
    chkb("lost", 1'b1, lostA);
    chkb("replaced", 1'b1, replA);
    chkb("valid", 1'b0, pv);
    chkb("overflow", 1'b0, ovfA);
    incr <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chkb("mismatch", 1'b1, misA);
    incr <= 1'b0;
    pwr(1'b0);
    chkb("replaced", 1'b0, replA);
    foreach (rows[i]) begin
      xfer(1'b1, abs_pos_pkg::OFS_CTRL, {28'h0, 2'h3, rows[i].res});
      @(posedge ref_clk);
      chkb("lost", 1'b0, lostA);
      move(1'b0, 8'h1);
      upd(2'h1);
      rdchk("in_turn", abs_pos_pkg::OFS_INTURN, rows[i].inTurn);
      rdchk("turn", abs_pos_pkg::OFS_TURN, 32'hffffffff);
      rdchk("total", abs_pos_pkg::OFS_FB_BEFORE, 32'hffffffff);
    end
    xfer(1'b1, abs_pos_pkg::OFS_CTRL, 32'hd);
    move(1'b1, 8'ha);
    upd(2'h1);
    rdchk("after_gear", abs_pos_pkg::OFS_FB_AFTER, 32'ha);
    rdchk("pos_err", abs_pos_pkg::OFS_POS_ERR, 32'ha);
    upd(2'h2);
    rdchk("before_gear", abs_pos_pkg::OFS_FB_BEFORE, 32'ha);
    rdchk("pos_err", abs_pos_pkg::OFS_POS_ERR, 32'h0);
    xfer(1'b1, abs_pos_pkg::OFS_IRQ_CLR, 32'h1f);
    xfer(1'b1, abs_pos_pkg::OFS_IRQ_EN, 32'h10);
    chkb("irq", 1'b0, irq);
    upd(2'h1);
    chkb("irq", 1'b1, irq);
    xfer(1'b1, abs_pos_pkg::OFS_IRQ_EN, 32'h0);
    @(posedge ref_clk);
    chkb("irq", 1'b0, irq);
    xfer(1'b1, abs_pos_pkg::OFS_IRQ_EN, 32'h10);
    @(posedge ref_clk);
    chkb("irq", 1'b1, irq);
    xfer(1'b1, abs_pos_pkg::OFS_IRQ_CLR, 32'h10);
    @(posedge ref_clk);
    chkb("irq", 1'b0, irq);
    pwr(1'b0);
    upd(2'h1);
    rdchk("kept", abs_pos_pkg::OFS_FB_BEFORE, 32'ha);
    chkb("valid", 1'b1, pv);
    xfer(1'b1, abs_pos_pkg::OFS_CTRL, 32'h205);
    upd(2'h1);
    xfer(1'b0, abs_pos_pkg::OFS_ENC_STAT, 32'h0);
    chkb("unsupported", 1'b1, got[3]);
    depl <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chkb("lost", 1'b1, lostA);
    depl <= 1'b0;
    repeat (6) @(posedge ref_clk);
    xfer(1'b1, abs_pos_pkg::OFS_CTRL, 32'h2d);
    @(posedge ref_clk);
    chkb("valid", 1'b1, pv);
    xfer(1'b1, abs_pos_pkg::OFS_CTRL, 32'h35);
    repeat (4) @(posedge ref_clk);
    chkb("valid", 1'b0, pv);
    xfer(1'b1, abs_pos_pkg::OFS_CTRL, 32'hd);
    @(posedge ref_clk);
    chkb("valid", 1'b1, pv);
    batRst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    batRst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chkb("valid", 1'b0, pv);
    tally_and_finish();
  end
endmodule : absolute_position_tracker_tb_top
